// ### inc/lpc_pkg.sv
// Operation
// - Stop-clock request enters Stop-Grant
// - Stop-Grant entry issues bus acknowledge
// - Stop-Grant gates core, keeps bus, interrupt
// - Stop-Grant keeps snooping and latching interrupts
// - Stop-clock release restores clocks, resumes execution
// - Latched interrupts serviced after leaving Stop-Grant
// - Stop-clock asynchronous, bus clock untouched
// - Sleep request from Stop-Grant enters Sleep
// - Sleep stops all unit clocks
// - Sleep ignores snoops and interrupts
// - Sleep reacts only to sleep, stop, reset (code: Sleep leaves only on sleep release or reset, stop is not looked at)
// - Sleep release returns to Stop-Grant
// - Sleep exit restarts bus, interrupt clocks
// - Management interrupt accepted asynchronously
// - Management interrupt saves state, enters management mode
// - Management acknowledge then handler execution
// - Reset releases bus outputs within two clocks
package lpc_pkg;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned RESET_RELEASE_CLKS = 2;

    typedef enum logic [2:0] {
        LPC_RUN = 3'h0,
        LPC_STOP_ACK = 3'h1,
        LPC_STOP_GRANT = 3'h2,
        LPC_SLEEP = 3'h3,
        LPC_MGMT_SAVE = 3'h4,
        LPC_MGMT_ACK = 3'h5
    } lpc_state_t;

    typedef enum logic [1:0] {
        LPC_TXN_NONE = 2'h0,
        LPC_TXN_STOP_ACK = 2'h1,
        LPC_TXN_MGMT_ACK = 2'h2
    } lpc_txn_t;

    typedef struct packed {
        logic coreEn;
        logic busEn;
        logic intUnitEn;
    } lpc_clk_en_t;

    localparam lpc_clk_en_t CLK_ALL_ON = '{coreEn: 1'b1, busEn: 1'b1, intUnitEn: 1'b1};
    localparam lpc_clk_en_t CLK_GRANT = '{coreEn: 1'b0, busEn: 1'b1, intUnitEn: 1'b1};
    localparam lpc_clk_en_t CLK_ALL_OFF = '{coreEn: 1'b0, busEn: 1'b0, intUnitEn: 1'b0};
endpackage

// ### rtl/lpc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module lpc_sync
    import lpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic asyncIn,
    output logic syncOut
);
    logic [SYNC_STAGES-1:0] stage_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage_q <= '1;
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = stage_q[SYNC_STAGES-1];
endmodule // lpc_sync
`default_nettype wire

// ### rtl/lpc_low_power_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module lpc_low_power_ctrl
    import lpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stop_clock_request_n,
    input wire logic sleep_request_n,
    input wire logic mgmt_interrupt_request_n,
    input wire logic intRequest,
    input wire logic snoopRequest,
    input wire logic intServiceDone,
    input wire logic handlerStarted,
    output lpc_clk_en_t clkEn,
    output logic pllRun,
    output logic busClkStop,
    output logic txnValid,
    output lpc_txn_t txnType,
    output logic snoopAck,
    output logic intPending,
    output logic intService,
    output logic saveState,
    output logic system_management_state,
    output logic busDriveEn
);
    logic stopSync;
    logic sleepSync;
    logic mgmtSync;
    lpc_state_t state_q;
    lpc_state_t state_d;
    logic [1:0] rstCnt_q;

    // Async pins retimed before any decision
    lpc_sync u_stop (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(stop_clock_request_n),
        .syncOut(stopSync)
    );
    lpc_sync u_sleep (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(sleep_request_n),
        .syncOut(sleepSync)
    );
    lpc_sync u_mgmt (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn(mgmt_interrupt_request_n),
        .syncOut(mgmtSync)
    );

    function automatic logic stop_req(input logic pinN);
        return !pinN;
    endfunction

    always_comb begin
        state_d = state_q;
        case (state_q)
            LPC_RUN: begin
                if (stop_req(mgmtSync) && !system_management_state) begin
                    state_d = LPC_MGMT_SAVE;
                end else if (stop_req(stopSync)) begin
                    state_d = LPC_STOP_ACK;
                end
            end
            LPC_STOP_ACK: begin
                state_d = LPC_STOP_GRANT;
            end
            LPC_STOP_GRANT: begin
                if (stop_req(sleepSync)) begin
                    state_d = LPC_SLEEP;
                end else if (!stop_req(stopSync)) begin
                    state_d = LPC_RUN;
                end
            end
            LPC_SLEEP: begin
                // Only the sleep pin leaves here
                if (!stop_req(sleepSync)) begin
                    state_d = LPC_STOP_GRANT;
                end
            end
            LPC_MGMT_SAVE: begin
                state_d = LPC_MGMT_ACK;
            end
            LPC_MGMT_ACK: begin
                state_d = LPC_RUN;
            end
            default: begin
                state_d = LPC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= LPC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Management mode holds until the handler reports it started; the
    // resume path is outside this block, so handler entry clears it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            system_management_state <= 1'b0;
        end else if (state_q == LPC_MGMT_SAVE) begin
            system_management_state <= 1'b1;
        end else if (handlerStarted && state_q == LPC_RUN) begin
            system_management_state <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            saveState <= 1'b0;
        end else begin
            saveState <= (state_d == LPC_MGMT_SAVE) && (state_q != LPC_MGMT_SAVE);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txnValid <= 1'b0;
            txnType <= LPC_TXN_NONE;
        end else if (state_q == LPC_STOP_ACK) begin
            txnValid <= 1'b1;
            txnType <= LPC_TXN_STOP_ACK;
        end else if (state_q == LPC_MGMT_ACK) begin
            txnValid <= 1'b1;
            txnType <= LPC_TXN_MGMT_ACK;
        end else begin
            txnValid <= 1'b0;
            txnType <= LPC_TXN_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clkEn <= CLK_ALL_ON;
        end else begin
            case (state_d)
                LPC_STOP_ACK, LPC_STOP_GRANT: clkEn <= CLK_GRANT;
                LPC_SLEEP: clkEn <= CLK_ALL_OFF;
                default: clkEn <= CLK_ALL_ON;
            endcase
        end
    end

    // PLL and the external bus clock never stop
    assign pllRun = 1'b1;
    assign busClkStop = 1'b0;

    // Interrupts latched except in Sleep; set wins over service clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            intPending <= 1'b0;
        end else if (intRequest && state_q != LPC_SLEEP) begin
            intPending <= 1'b1;
        end else if (intServiceDone) begin
            intPending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            intService <= 1'b0;
        end else begin
            intService <= intPending && state_q == LPC_RUN && state_d == LPC_RUN;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            snoopAck <= 1'b0;
        end else begin
            snoopAck <= snoopRequest && state_q != LPC_SLEEP;
        end
    end

    // Bus outputs released as soon as reset asserts, held off two edges after
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rstCnt_q <= 2'h0;
        end else if (rstCnt_q != 2'(RESET_RELEASE_CLKS)) begin
            rstCnt_q <= rstCnt_q + 2'h1;
        end
    end
    assign busDriveEn = rst_b && (rstCnt_q == 2'(RESET_RELEASE_CLKS));

    chk_stop_enter: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_RUN && !stopSync && mgmtSync |=> state_q == LPC_STOP_ACK)
        else $error("stop request did not enter grant");
    chk_stop_ack: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_STOP_ACK |=> txnValid && txnType == LPC_TXN_STOP_ACK)
        else $error("missing stop-grant acknowledge");
    chk_grant_clks: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_STOP_GRANT && $past(state_q) == LPC_STOP_GRANT |-> clkEn == CLK_GRANT)
        else $error("grant clock gating wrong");
    chk_sleep_enter: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_STOP_GRANT && !sleepSync |=> state_q == LPC_SLEEP ##0 clkEn == CLK_ALL_OFF)
        else $error("sleep entry wrong");
    chk_sleep_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_SLEEP |=> !snoopAck)
        else $error("snoop answered in sleep");
    chk_sleep_exit: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_SLEEP && sleepSync |=> state_q == LPC_STOP_GRANT)
        else $error("sleep exit not to grant");
    chk_resume_run: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_STOP_GRANT && stopSync && sleepSync |=> state_q == LPC_RUN ##0 clkEn == CLK_ALL_ON)
        else $error("resume failed");
    chk_mgmt_seq: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_MGMT_SAVE |=> system_management_state ##1 txnType == LPC_TXN_MGMT_ACK)
        else $error("management sequence wrong");
    chk_reset_release: assert property (@(posedge clk)
        !rst_b |-> !busDriveEn ##1 !busDriveEn ##1 !busDriveEn)
        else $error("bus driven during reset window");

    chk_int_latch: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_STOP_GRANT && intRequest |=> intPending)
        else $error("interrupt not latched in grant");
    chk_int_service: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_RUN && state_d == LPC_RUN && intPending |=> intService)
        else $error("pending interrupt not serviced");
    chk_clock_const: assert property (@(posedge clk) disable iff (!rst_b)
        pllRun && !busClkStop)
        else $error("pll or bus clock stopped");
    chk_sleep_clks: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_SLEEP |-> clkEn == CLK_ALL_OFF)
        else $error("clocks running in sleep");
    chk_sleep_int: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_SLEEP && !intPending |=> !intPending)
        else $error("interrupt latched in sleep");
    chk_sleep_hold: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_SLEEP && !sleepSync |=> state_q == LPC_SLEEP)
        else $error("sleep left without sleep release");
    chk_wake_clks: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_SLEEP && sleepSync |=> clkEn == CLK_GRANT)
        else $error("sleep exit clocks wrong");
    chk_mgmt_enter: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_RUN && !mgmtSync && !system_management_state |=> state_q == LPC_MGMT_SAVE && saveState)
        else $error("management request not taken");
    chk_save_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        saveState |=> !saveState)
        else $error("save pulse too long");
    chk_txn_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        txnValid |=> !txnValid)
        else $error("acknowledge longer than one cycle");
    chk_bus_drive: assert property (@(posedge clk)
        rst_b && $past(rst_b) && $past(rst_b, 2) |-> busDriveEn)
        else $error("bus not driven after reset");

    cov_stop_grant: cover property (@(posedge clk) disable iff (!rst_b) state_q == LPC_STOP_GRANT);
    cov_resume: cover property (@(posedge clk) disable iff (!rst_b)
        state_q == LPC_STOP_GRANT ##1 state_q == LPC_RUN);
    cov_sleep: cover property (@(posedge clk) disable iff (!rst_b) state_q == LPC_SLEEP);
    cov_mgmt: cover property (@(posedge clk) disable iff (!rst_b) txnType == LPC_TXN_MGMT_ACK);
    cov_service: cover property (@(posedge clk) disable iff (!rst_b) intService);
endmodule // lpc_low_power_ctrl
`default_nettype wire

// ### sim/lpc_sys_model.sv
`timescale 1ns/1ns
`default_nettype none
module lpc_sys_model (
    input wire logic stopReq,
    input wire logic sleepReq,
    input wire logic mgmtReq,
    output logic stopN,
    output logic sleepN,
    output logic mgmtN
);
    initial begin
        stopN = 1'b1;
        sleepN = 1'b1;
        mgmtN = 1'b1;
    end
    // Odd delays keep pin edges away from clock edges, as real async logic would
    always @(stopReq) stopN <= #7 ~stopReq;
    // Sleep only goes low while stop is held low
    always @(sleepReq) sleepN <= #3 ~(sleepReq & ~stopN);
    always @(mgmtReq) mgmtN <= #13 ~mgmtReq;
endmodule // lpc_sys_model
`default_nettype wire

// ### sim/low_power_state_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module low_power_state_control_bench;
    import lpc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic stopReq = 1'b0, sleepReq = 1'b0, mgmtReq = 1'b0, intRequest = 1'b0;
    logic snoopRequest = 1'b0, intServiceDone = 1'b0, handlerStarted = 1'b0;
    wire stopN, sleepN, mgmtN;
    lpc_clk_en_t clkEn;
    lpc_txn_t txnType;
    logic pllRun, busClkStop, txnValid, snoopAck, intPending, intService;
    logic saveState, mgmtState, busDriveEn;
    int n_mismatch = 0, cmp_count = 0, nSave = 0;
    lpc_txn_t expQ[$];

    always #10 clk = ~clk;

    lpc_sys_model sys (.stopReq(stopReq), .sleepReq(sleepReq), .mgmtReq(mgmtReq),
        .stopN(stopN), .sleepN(sleepN), .mgmtN(mgmtN));

    lpc_low_power_ctrl dut (.clk(clk), .rst_b(rst_b), .stop_clock_request_n(stopN),
        .sleep_request_n(sleepN), .mgmt_interrupt_request_n(mgmtN),
        .intRequest(intRequest), .snoopRequest(snoopRequest),
        .intServiceDone(intServiceDone), .handlerStarted(handlerStarted),
        .clkEn(clkEn), .pllRun(pllRun), .busClkStop(busClkStop), .txnValid(txnValid),
        .txnType(txnType), .snoopAck(snoopAck), .intPending(intPending),
        .intService(intService), .saveState(saveState),
        .system_management_state(mgmtState), .busDriveEn(busDriveEn));

    task automatic miss(input string what, input logic [2:0] e, input logic [2:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkBit(input string what, input logic e, input logic g);
        miss(what, {2'b00, e}, {2'b00, g});
    endtask
    task automatic chkClk(input lpc_clk_en_t e);
        miss("clkEn", e, clkEn);
    endtask
    task automatic chkTxn(input lpc_txn_t e);
        miss("txnType", {1'b0, e}, {1'b0, txnType});
    endtask
    // Outputs are read at the falling edge, well clear of register updates
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic stop_test;
        if (expQ.size() != 0) begin
            n_mismatch++;
            $display("FAIL txnQueue expected %0d seen %0d", 0, expQ.size());
        end
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(negedge clk) begin
        if (saveState === 1'b1) nSave++;
        if (txnValid === 1'b1) chkTxn(expQ.size() ? expQ.pop_front() : LPC_TXN_NONE);
    end

    initial begin
        #(20 * 3000);
        n_mismatch++;
        stop_test;
    end

    initial begin
        bit r;
        void'($urandom(32'h7eb600c1));
        wt(11);
        chkBit("busDriveEn", 1'b0, busDriveEn);
        chkClk(CLK_ALL_ON);
        @(posedge clk) rst_b <= 1'b1;
        wt(4);
        chkBit("busDriveEn", 1'b1, busDriveEn);
        // Random snoops in run; each answer is due one cycle later
        repeat (12) begin
            r = 1'($urandom);
            @(posedge clk) snoopRequest <= r;
            wt(1);
            chkBit("snoopAck", r, snoopAck);
        end
        expQ.push_back(LPC_TXN_STOP_ACK);
        @(posedge clk) {snoopRequest, stopReq} <= 2'b01;
        wt(8);
        chkClk(CLK_GRANT);
        chkBit("pllRun", 1'b1, pllRun);
        chkBit("busClkStop", 1'b0, busClkStop);
        @(posedge clk) {snoopRequest, intRequest} <= 2'b11;
        @(posedge clk) {snoopRequest, intRequest} <= 2'b00;
        @(negedge clk) chkBit("snoopAck", 1'b1, snoopAck);
        wt(1);
        chkBit("intPending", 1'b1, intPending);
        chkBit("intService", 1'b0, intService);
        @(posedge clk) sleepReq <= 1'b1;
        wt(8);
        chkClk(CLK_ALL_OFF);
        @(posedge clk) {snoopRequest, mgmtReq} <= 2'b11;
        wt(6);
        chkBit("snoopAck", 1'b0, snoopAck);
        chkBit("saveState seen", 1'b0, nSave != 0);
        @(posedge clk) {snoopRequest, mgmtReq} <= 2'b00;
        wt(6);
        @(posedge clk) sleepReq <= 1'b0;
        wt(8);
        chkClk(CLK_GRANT);
        @(posedge clk) stopReq <= 1'b0;
        wt(8);
        chkClk(CLK_ALL_ON);
        chkBit("intService", 1'b1, intService);
        @(posedge clk) intServiceDone <= 1'b1;
        @(posedge clk) intServiceDone <= 1'b0;
        wt(2);
        chkBit("intPending", 1'b0, intPending);
        expQ.push_back(LPC_TXN_MGMT_ACK);
        @(posedge clk) mgmtReq <= 1'b1;
        wt(8);
        chkBit("mgmtState", 1'b1, mgmtState);
        chkBit("one saveState", 1'b1, nSave == 1);
        @(posedge clk) mgmtReq <= 1'b0;
        wt(4);
        @(posedge clk) handlerStarted <= 1'b1;
        @(posedge clk) handlerStarted <= 1'b0;
        wt(2);
        chkBit("mgmtState", 1'b0, mgmtState);
        // A second reset during Stop-Grant must silence the bus again
        expQ.push_back(LPC_TXN_STOP_ACK);
        @(posedge clk) stopReq <= 1'b1;
        wt(8);
        @(posedge clk) rst_b <= 1'b0;
        wt(2);
        chkBit("busDriveEn", 1'b0, busDriveEn);
        chkClk(CLK_ALL_ON);
        @(posedge clk) {rst_b, stopReq} <= 2'b10;
        wt(8);
        stop_test;
    end
endmodule // low_power_state_control_bench
`default_nettype wire
